// file: bench/dpc_master_model.sv
// Fieldbus master model that hands command words to the decoder.
// Assumes the caller enters send just after a rising clock edge.
`timescale 1ns/1ps

module dpc_master_model (
  // Clock
  input wire logic clk,
  // Command word toward the device
  output logic [15:0] driveCommandWord,
  output logic commandStrobe
);
  initial
  begin
    driveCommandWord = 16'h0000;
    commandStrobe = 1'b0;
  end

  // Once taken, the word bus shows the inverse so a stale value never
  // looks like a fresh one.
  // One edge passes before the new word goes out. Back-to-back calls then
  // never lower and raise the strobe in the same time step.
  task automatic send(input logic [15:0] w);
    @(posedge clk);
    #1 driveCommandWord = w;
    commandStrobe = 1'b1;
    @(posedge clk);
    #1 commandStrobe = 1'b0;
    driveCommandWord = ~w;
  endtask
endmodule

// file: bench/dpc_profile_checker.sv
// Concurrent checks on the decoder and condition word ports.
// Assumes one clock domain and the asynchronous active-high reset.
`timescale 1ns/1ps

module dpc_profile_checker
  import dpc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Inputs watched
  input wire logic [15:0] driveCommandWord,
  input wire logic commandStrobe,
  input wire logic [1:0] reverseSource,
  input wire logic tripped,
  input wire logic linkLost,
  // Outputs watched
  input wire logic [1:0] presetSelect,
  input wire logic [2:0] stopMode,
  input wire logic outputOff,
  input wire logic freezeFreq,
  input wire logic tripReset,
  input wire logic jogSelect,
  input wire logic rampPair2,
  input wire logic reverse,
  input wire logic [15:0] driveConditionWord
);
  logic lastB7;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // ==========================================================================
  // Helper state
  always_ff @(posedge clk or posedge rst)
    if (rst)
      lastB7 <= 1'b0;
    else if (commandStrobe && driveCommandWord[10])
      lastB7 <= driveCommandWord[7];

  sequence take_s;
    commandStrobe && driveCommandWord[10];
  endsequence
  sequence rise_s;
    take_s ##0 (driveCommandWord[7] && !lastB7);
  endsequence

  // ==========================================================================
  // Assertions
  a_preset_freeze: assert property (take_s |=>
    presetSelect == $past(driveCommandWord[1:0])
    && freezeFreq == !$past(driveCommandWord[5])) else $error("preset");
  a_jog_ramp: assert property (take_s |=>
    jogSelect == $past(driveCommandWord[8])
    && rampPair2 == $past(driveCommandWord[9])) else $error("jog ramp");
  a_ignore_invalid: assert property (
    commandStrobe && !driveCommandWord[10] |=> $stable(presetSelect)
    && $stable(jogSelect)) else $error("invalid word used");
  a_coast_off: assert property (take_s ##0 !driveCommandWord[3] |=>
    outputOff && stopMode == DPC_COAST) else $error("coast");
  a_reset_pulse: assert property (rise_s |=> tripReset)
    else $error("no trip reset");
  a_no_false_reset: assert property (
    !(commandStrobe && driveCommandWord[10] && driveCommandWord[7]
    && !lastB7) |=> !tripReset) else $error("false trip reset");
  a_trip_status: assert property (!linkLost |=>
    driveConditionWord[3] == $past(tripped)
    && !($past(tripped) && driveConditionWord[0])) else $error("trip");
  a_link_zero: assert property (
    linkLost |=> driveConditionWord == 16'h0000) else $error("link");
  a_unused_zero: assert property (driveConditionWord[5] == 1'b0)
    else $error("unused bit set");
  a_reverse_gate: assert property (
    reverse |-> reverseSource != DPC_REV_DIGITAL) else $error("reverse");
endmodule

bind dpc_profile dpc_profile_checker dpc_profile_checker_i (.*);

// file: bench/dpc_profile_tb.sv
// Self-checking bench for the drive profile decoder.
// Assumes the master model and the checker are compiled before it.
`timescale 1ns/1ps
`define CHK(a, b) begin checksDone++; if ((a) !== (b)) begin numErrors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end

module dpc_profile_tb;
  import dpc_pkg::*;
  logic clk = 0, rst = 1, linkLost = 0, relay1FromWord = 1;
  logic relay2FromWord = 1, multiSetup = 1, dinDcBrake = 0;
  logic dinCoast = 0, dinResetCoast = 0, commandStrobe;
  logic [1:0] reverseSource = 2'b01, presetSelect, setupSelect;
  logic [2:0] stopMode;
  logic outputOff, freezeFreq, startPermit, tripReset, jogSelect;
  logic rampPair2, relay1, relay2, reverse;
  logic [16:0] s = '0;
  logic [15:0] driveCommandWord, driveConditionWord, outv;
  int numErrors = 0, checksDone = 0, cyc = 0;
  // Word in the upper half, expected packed outputs in the lower half.
  logic [31:0] rows [9] = '{32'h047fc100, 32'h07fc01e0, 32'hfcf54c1f,
    32'h047a9000, 32'h046c1800, 32'h043c2000, 32'h040c0300,
    32'h00000300, 32'h04ec1880};
  logic [16:0] sv [5] = '{17'h00000, 17'h1ffff, 17'h0aaaa, 17'h15555,
    17'h00208};

  dpc_master_model dpc_master_model_i (.clk, .driveCommandWord,
    .commandStrobe);
  dpc_profile dpc_profile_i (.clk, .rst, .driveCommandWord,
    .commandStrobe, .relay1FromWord, .relay2FromWord, .multiSetup,
    .reverseSource, .dinDcBrake, .dinCoast, .dinResetCoast,
    .controlReady(s[0]), .driveReady(s[1]), .motorReleased(s[2]),
    .tripped(s[3]), .errorNoTrip(s[4]), .tripLocked(s[5]),
    .warning(s[6]), .speedAtRef(s[7]), .localStop(s[8]),
    .localOperation(s[9]), .freqInLimits(s[10]), .startPresent(s[11]),
    .freqAboveZero(s[12]), .overTempHalt(s[13]),
    .dcVoltageFault(s[14]), .currentLimit(s[15]), .thermalTimer(s[16]),
    .linkLost, .presetSelect, .stopMode, .outputOff, .freezeFreq,
    .startPermit, .tripReset, .jogSelect, .rampPair2, .relay1, .relay2,
    .setupSelect, .reverse, .driveConditionWord);

  assign outv = {presetSelect, stopMode, outputOff, freezeFreq,
    startPermit, tripReset, jogSelect, rampPair2, relay1, relay2,
    setupSelect, reverse};

  function automatic logic [15:0] expSt(logic [16:0] v);
    return {v[16:13], v[11] | v[12], v[10], ~(v[8] | v[9]), v[7:5],
      1'b0, v[4:3], ~v[2], v[1], v[0] & ~v[3]};
  endfunction

  task automatic conclude();
    if (numErrors == 0 && checksDone > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
    forever #12.5 clk = ~clk;

  // The whole run needs under a hundred cycles.
  always @(posedge clk)
    if (++cyc == 500)
    begin
      numErrors++;
      $display("[ERR] %0t timeout", $time);
      conclude();
    end

  initial
  begin
    repeat (5) @(posedge clk);
    #1 rst = 0;
    foreach (rows[i])
    begin
      dpc_master_model_i.send(rows[i][31:16]);
      `CHK(outv, rows[i][15:0])
    end
    foreach (sv[i])
    begin
      s = sv[i];
      @(posedge clk);
      #1 `CHK(driveConditionWord, expSt(sv[i]))
    end
    linkLost = 1;
    @(posedge clk);
    #1 `CHK(driveConditionWord, 16'h0000)
    linkLost = 0;
    dinDcBrake = 1;
    @(posedge clk);
    #1 `CHK(stopMode, DPC_DCBRAKE)
    dinResetCoast = 1;
    @(posedge clk);
    #1 `CHK(outputOff, 1'b1)
    dinDcBrake = 0;
    dinResetCoast = 0;
    relay1FromWord = 0;
    multiSetup = 0;
    for (int k = 0; k < 4; k++)
    begin
      reverseSource = 2'(k);
      dpc_master_model_i.send(16'hfcf5);
      `CHK(outv, k != 0 ? 16'h4c09 : 16'h4c08)
    end
    rst = 1;
    @(posedge clk);
    #1 `CHK({outv, driveConditionWord}, 32'h0e000000)
    rst = 0;
    dpc_master_model_i.send(16'h04ff);
    `CHK(outv, 16'hc180)
    conclude();
  end
endmodule

// file: common/dpc_pkg.sv
// Constants shared by the drive profile command and condition word logic.
// Assumes a 16-bit command word delivered by the telegram decoder.
package dpc_pkg;

  // ==========================================================================
  // Command word bit positions
  localparam int CMD_PRESET_LSB = 0;
  localparam int CMD_PRESET_MSB = 1;
  localparam int CMD_NO_DCBRAKE = 2;
  localparam int CMD_NO_COAST = 3;
  localparam int CMD_NO_QSTOP = 4;
  localparam int CMD_NO_HOLD = 5;
  localparam int CMD_START = 6;
  localparam int CMD_RESET = 7;
  localparam int CMD_JOG = 8;
  localparam int CMD_RAMP2 = 9;
  localparam int CMD_VALID = 10;
  localparam int CMD_RELAY1 = 11;
  localparam int CMD_RELAY2 = 12;
  localparam int CMD_SETUP_LSB = 13;
  localparam int CMD_SETUP_MSB = 14;
  localparam int CMD_REVERSE = 15;

  // ==========================================================================
  // Condition word bit positions
  localparam int STS_CTRL_READY = 0;
  localparam int STS_DRIVE_READY = 1;
  localparam int STS_ENABLE = 2;
  localparam int STS_TRIP = 3;
  localparam int STS_ERROR = 4;
  localparam int STS_UNUSED = 5;
  localparam int STS_TRIPLOCK = 6;
  localparam int STS_WARNING = 7;
  localparam int STS_AT_REF = 8;
  localparam int STS_BUS_CTRL = 9;
  localparam int STS_FREQ_OK = 10;
  localparam int STS_RUNNING = 11;
  localparam int STS_OVERTEMP = 12;
  localparam int STS_VOLTAGE = 13;
  localparam int STS_TORQUE = 14;
  localparam int STS_TIMER = 15;

  // ==========================================================================
  // Reset values
  // Command word reset value: every stop bit active, control ignored.
  localparam logic [15:0] CMD_RESET_VALUE = 16'h0000;
  localparam logic [15:0] STS_RESET_VALUE = 16'h0000;

  // Reversing source selections.
  typedef enum logic [1:0] {
    DPC_REV_DIGITAL = 2'b00,
    DPC_REV_SERIAL = 2'b01,
    DPC_REV_OR = 2'b10,
    DPC_REV_AND = 2'b11
  } dpc_rev_e;

  // Stop mode chosen from the command word, in priority order.
  typedef enum logic [2:0] {
    DPC_RUN = 3'b000,
    DPC_COAST = 3'b001,
    DPC_DCBRAKE = 3'b010,
    DPC_QSTOP = 3'b011,
    DPC_RAMPSTOP = 3'b100
  } dpc_stop_e;

endpackage

// file: src/dpc_profile.sv
// Command word decoder and condition word builder for the drive profile.
// Assumes the telegram decoder strobes a fresh command word on the device
// clock, and that drive state inputs are synchronous to the same clock.
`timescale 1ns/1ps

module dpc_profile
  import dpc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Command word from the telegram decoder
  input wire logic [15:0] driveCommandWord,
  input wire logic commandStrobe,
  // Configuration from the parameter store
  input wire logic relay1FromWord,
  input wire logic relay2FromWord,
  input wire logic multiSetup,
  input wire logic [1:0] reverseSource,
  // Digital input stop requests
  input wire logic dinDcBrake,
  input wire logic dinCoast,
  input wire logic dinResetCoast,
  // Drive state from the motor-control core
  input wire logic controlReady,
  input wire logic driveReady,
  input wire logic motorReleased,
  input wire logic tripped,
  input wire logic errorNoTrip,
  input wire logic tripLocked,
  input wire logic warning,
  input wire logic speedAtRef,
  input wire logic localStop,
  input wire logic localOperation,
  input wire logic freqInLimits,
  input wire logic startPresent,
  input wire logic freqAboveZero,
  input wire logic overTempHalt,
  input wire logic dcVoltageFault,
  input wire logic currentLimit,
  input wire logic thermalTimer,
  input wire logic linkLost,
  // Decoded commands to the motor-control core
  output logic [1:0] presetSelect,
  output logic [2:0] stopMode,
  output logic outputOff,
  output logic freezeFreq,
  output logic startPermit,
  output logic tripReset,
  output logic jogSelect,
  output logic rampPair2,
  output logic relay1,
  output logic relay2,
  output logic [1:0] setupSelect,
  output logic reverse,
  // Condition word back to the master
  output logic [15:0] driveConditionWord
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [15:0] cmd;
    logic resetPrev;
    logic tripReset;
    logic [15:0] status;
  } dpc_state_s;

  dpc_state_s state;
  dpc_state_s next_state;
  logic [15:0] activeCmd;
  logic revAllowed;
  logic frozenStop;
  dpc_stop_e next_stop;

  // ==========================================================================
  // Command decode
  always_comb
  begin
    next_state = state;
    next_state.tripReset = 1'b0;
    // A word with the valid bit clear is dropped whole, so the last valid
    // word keeps steering the drive.
    if (commandStrobe && driveCommandWord[CMD_VALID])
    begin
      next_state.cmd = driveCommandWord;
      // Reset acts on a rising edge between accepted words only.
      next_state.resetPrev = driveCommandWord[CMD_RESET];
      next_state.tripReset = driveCommandWord[CMD_RESET] &
                             ~state.resetPrev;
    end

    next_state.status = STS_RESET_VALUE;
    if (!linkLost)
    begin
      next_state.status[STS_CTRL_READY] = controlReady & ~tripped;
      next_state.status[STS_DRIVE_READY] = driveReady;
      next_state.status[STS_ENABLE] = ~motorReleased;
      next_state.status[STS_TRIP] = tripped;
      next_state.status[STS_ERROR] = errorNoTrip;
      next_state.status[STS_UNUSED] = 1'b0;
      next_state.status[STS_TRIPLOCK] = tripLocked;
      next_state.status[STS_WARNING] = warning;
      next_state.status[STS_AT_REF] = speedAtRef;
      next_state.status[STS_BUS_CTRL] = ~(localStop | localOperation);
      next_state.status[STS_FREQ_OK] = freqInLimits;
      next_state.status[STS_RUNNING] = startPresent | freqAboveZero;
      next_state.status[STS_OVERTEMP] = overTempHalt;
      next_state.status[STS_VOLTAGE] = dcVoltageFault;
      next_state.status[STS_TORQUE] = currentLimit;
      next_state.status[STS_TIMER] = thermalTimer;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= '{cmd: CMD_RESET_VALUE, resetPrev: 1'b0, tripReset: 1'b0,
                 status: STS_RESET_VALUE};
    end
    else
    begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Outputs
  assign activeCmd = state.cmd;
  assign revAllowed = (reverseSource == DPC_REV_SERIAL) ||
                      (reverseSource == DPC_REV_OR) ||
                      (reverseSource == DPC_REV_AND);
  // While frozen, quick and ramp stops are disregarded.
  assign frozenStop = ~activeCmd[CMD_NO_HOLD];

  always_comb
  begin
    next_stop = DPC_RUN;
    if (!activeCmd[CMD_NO_COAST] || dinCoast || dinResetCoast)
    begin
      next_stop = DPC_COAST;
    end
    else if (!activeCmd[CMD_NO_DCBRAKE] || dinDcBrake)
    begin
      next_stop = DPC_DCBRAKE;
    end
    else if (!frozenStop && !activeCmd[CMD_NO_QSTOP])
    begin
      next_stop = DPC_QSTOP;
    end
    else if (!frozenStop && !activeCmd[CMD_START])
    begin
      next_stop = DPC_RAMPSTOP;
    end
    else
    begin
      next_stop = DPC_RUN;
    end
  end

  assign presetSelect = activeCmd[CMD_PRESET_MSB:CMD_PRESET_LSB];
  assign stopMode = next_stop;
  assign outputOff = (next_stop == DPC_COAST);
  assign freezeFreq = frozenStop;
  assign startPermit = (next_stop == DPC_RUN);
  assign tripReset = state.tripReset;
  assign jogSelect = activeCmd[CMD_JOG];
  assign rampPair2 = activeCmd[CMD_RAMP2];
  assign relay1 = relay1FromWord & activeCmd[CMD_RELAY1];
  assign relay2 = relay2FromWord & activeCmd[CMD_RELAY2];
  assign setupSelect = multiSetup ?
      activeCmd[CMD_SETUP_MSB:CMD_SETUP_LSB] : 2'h0;
  assign reverse = revAllowed & activeCmd[CMD_REVERSE];
  assign driveConditionWord = state.status;

endmodule
